// ===== logic/brsa_defines.svh
// Opcode codes, flag positions and reset values for the rotate/subtract/skip datapath
`ifndef BRSA_DEFINES_SVH
`define BRSA_DEFINES_SVH

// ==========================================================================
// Operation codes
`define BRSA_OP_NOP            5'h00
`define BRSA_OP_ROT_L_W        5'h01
`define BRSA_OP_ROT_LC_M       5'h02
`define BRSA_OP_ROT_LC_W       5'h03
`define BRSA_OP_ROT_R_M        5'h04
`define BRSA_OP_ROT_R_W        5'h05
`define BRSA_OP_ROT_RC_M       5'h06
`define BRSA_OP_ROT_RC_W       5'h07
`define BRSA_OP_MWB_W          5'h08
`define BRSA_OP_MWB_IMM        5'h09
`define BRSA_OP_MWB_M          5'h0A
`define BRSA_OP_SUB_W          5'h0B
`define BRSA_OP_SUB_M          5'h0C
`define BRSA_OP_SUB_IMM        5'h0D
`define BRSA_OP_DSZ_M          5'h0E
`define BRSA_OP_DSZ_W          5'h0F
`define BRSA_OP_ISZ_M          5'h10
`define BRSA_OP_ISZ_W          5'h11
`define BRSA_OP_NZ_BYTE        5'h12
`define BRSA_OP_NZ_BIT         5'h13
`define BRSA_OP_SET_BYTE       5'h14
`define BRSA_OP_SET_BIT        5'h15
`define BRSA_OP_SWAP_M         5'h16

// ==========================================================================
// Flag vector positions
`define BRSA_FLAG_C            0
`define BRSA_FLAG_HALF         1
`define BRSA_FLAG_Z            2
`define BRSA_FLAG_EXCESS       3
`define BRSA_FLAG_SIGN         4
`define BRSA_FLAG_MBZ          5
`define BRSA_FLAG_W            6

// ==========================================================================
// Reset values and the all-ones byte written by byte set
`define BRSA_RST_BYTE          8'h00
`define BRSA_RST_FLAGS         6'h00
`define BRSA_ALL_ONES          8'hFF

`endif

// ===== logic/brsa_pkg.sv
// Types shared by the rotate/subtract/skip datapath
package brsa_pkg;

    // ======================================================================
    // Operation select
    typedef logic [4:0] brsa_op_t;

    // ======================================================================
    // Flag vector: {mbz, sign, excess, z, half, c}
    typedef logic [5:0] brsa_flags_t;

endpackage : brsa_pkg

// ===== logic/brsa_subtractor.sv
// Eight-bit subtractor with carry-as-inverted-borrow and flag generation
`timescale 1ns/1ps
`include "brsa_defines.svh"

module brsa_subtractor (
    // Operands
    input  wire logic [7:0] minuend_i,
    input  wire logic [7:0] subtrahend_i,
    input  wire logic       borrow_in_i,
    input  wire logic       prev_z_i,
    input  wire logic       chain_i,
    // Results
    output logic      [7:0] diff_o,
    output brsa_pkg::brsa_flags_t flags_o
);

    logic [8:0] full;
    logic [4:0] low;
    logic [9:0] sfull;
    logic       zero;

    always_comb begin
        full  = {1'b0, minuend_i} - {1'b0, subtrahend_i} - {8'h00, borrow_in_i};
        low   = {1'b0, minuend_i[3:0]} - {1'b0, subtrahend_i[3:0]} - {4'h0, borrow_in_i};
        sfull = {{2{minuend_i[7]}}, minuend_i} - {{2{subtrahend_i[7]}}, subtrahend_i}
              - {9'h000, borrow_in_i};
        zero  = (full[7:0] == 8'h00);
        diff_o = full[7:0];
        flags_o[`BRSA_FLAG_C]      = ~full[8];
        flags_o[`BRSA_FLAG_HALF]   = ~low[4];
        flags_o[`BRSA_FLAG_Z]      = zero;
        flags_o[`BRSA_FLAG_EXCESS] = (minuend_i[7] ^ subtrahend_i[7]) & (minuend_i[7] ^ full[7]);
        flags_o[`BRSA_FLAG_SIGN]   = sfull[9];
        // With chain_i set, multi-byte zero only survives if the earlier byte was zero too; without it, it is the plain zero
        flags_o[`BRSA_FLAG_MBZ]    = chain_i ? (zero & prev_z_i) : zero;
    end

endmodule : brsa_subtractor

// ===== logic/brsa_alu.sv
// Rotate, subtract, skip, set and swap execution datapath of an 8-bit core
// ==========================================================================
// Overview of operation
// - Rotate left into working register, bit 7 into bit 0, no flags.
// - Rotate memory left through carry; old carry to bit 0, bit 7 to carry.
// - Same nine-bit left rotation, result to working register, carry updated.
// - Rotate memory right, bit 0 into bit 7, written back, no flags.
// - Same right rotation delivered to working register, memory and flags kept.
// - Rotate memory right through carry; old carry to bit 7, bit 0 to carry.
// - Nine-bit right rotation to working register, carry from bit 0.
// - Working minus memory minus inverted carry into working register, six flags.
// - Subtraction carry is zero when negative, one when zero or positive.
// - Working minus immediate minus inverted carry into working register, six flags.
// - Borrow subtraction written to memory instead, same flags.
// - Working minus memory, no carry in, into working register, six flags.
// - Plain subtraction result written to memory, same six flags.
// - Working minus immediate into working register, six flags.
// - Decrement memory, write back, skip next instruction when result zero.
// - Decrement into working register only, skip when result zero.
// - Increment memory, write back, skip when result wraps to zero.
// - Increment into working register only, skip when result zero.
// - Byte or bit nonzero test skips the next instruction, no flags.
// - Byte set writes all ones to memory, no flags.
// - Bit set forces the selected memory bit to one, rest kept.
// - Nibble swap of memory byte written back, no flags.
// ==========================================================================
`timescale 1ns/1ps
`include "brsa_defines.svh"

module brsa_alu (
    // Clock and reset
    input  wire logic                   sys_clk_i,
    input  wire logic                   nrst_i,
    // Instruction issue from decode
    input  wire logic                   issue_i,
    input  wire brsa_pkg::brsa_op_t     op_i,
    input  wire logic [7:0]             mem_data_i,
    input  wire logic [7:0]             imm_i,
    input  wire logic [2:0]             bit_sel_i,
    input  wire logic                   mbz_chain_i,
    // Working register and flags
    output logic [7:0]                  working_register_o,
    output logic                        carry_flag_o,
    output logic                        half_carry_flag_o,
    output logic                        zero_flag_o,
    output logic                        twos_complement_excess_flag_o,
    output logic                        signed_borrow_bit_o,
    output logic                        multi_byte_zero_bit_o,
    // Data memory write back
    output logic                        mem_we_o,
    output logic [7:0]                  mem_wdata_o,
    // Skip control toward fetch
    output logic                        skip_o,
    output logic                        busy_o
);

    // ======================================================================
    // Architectural state
    logic [7:0]            work_q;
    brsa_pkg::brsa_flags_t flags_q;
    logic                  mem_we_q;
    logic [7:0]            mem_wdata_q;
    logic                  skip_q;

    // ======================================================================
    // Subtractor
    logic                  sub_borrow_sel;
    logic [7:0]            sub_rhs;
    logic [7:0]            sub_diff;
    brsa_pkg::brsa_flags_t sub_flags;

    always_comb begin
        sub_rhs        = mem_data_i;
        sub_borrow_sel = 1'b0;
        unique case (op_i)
            `BRSA_OP_MWB_W, `BRSA_OP_MWB_M: begin
                sub_borrow_sel = ~flags_q[`BRSA_FLAG_C];
            end
            `BRSA_OP_MWB_IMM: begin
                sub_rhs        = imm_i;
                sub_borrow_sel = ~flags_q[`BRSA_FLAG_C];
            end
            `BRSA_OP_SUB_IMM: begin
                sub_rhs = imm_i;
            end
            default: begin
                sub_rhs        = mem_data_i;
                sub_borrow_sel = 1'b0;
            end
        endcase
    end

    brsa_subtractor u_sub (
        .minuend_i    (work_q),
        .subtrahend_i (sub_rhs),
        .borrow_in_i  (sub_borrow_sel),
        .prev_z_i     (flags_q[`BRSA_FLAG_Z]),
        .chain_i      (mbz_chain_i),
        .diff_o       (sub_diff),
        .flags_o      (sub_flags)
    );

    // ======================================================================
    // Result selection
    logic [7:0] res;
    logic       wr_work;
    logic       wr_mem;
    logic       upd_c;
    logic       new_c;
    logic       upd_arith;
    logic       do_skip;
    logic [7:0] dec_v;
    logic [7:0] inc_v;
    logic [7:0] bit_mask;

    // Decoded bit position as a one-hot mask
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_mask
            assign bit_mask[gi] = (bit_sel_i == 3'(gi));
        end
    endgenerate

    always_comb begin
        res       = mem_data_i;
        wr_work   = 1'b0;
        wr_mem    = 1'b0;
        upd_c     = 1'b0;
        new_c     = flags_q[`BRSA_FLAG_C];
        upd_arith = 1'b0;
        do_skip   = 1'b0;
        dec_v     = mem_data_i - 8'h01;
        inc_v     = mem_data_i + 8'h01;
        unique case (op_i)
            `BRSA_OP_ROT_L_W: begin
                res     = {mem_data_i[6:0], mem_data_i[7]};
                wr_work = 1'b1;
            end
            `BRSA_OP_ROT_LC_M: begin
                res    = {mem_data_i[6:0], flags_q[`BRSA_FLAG_C]};
                wr_mem = 1'b1;
                upd_c  = 1'b1;
                new_c  = mem_data_i[7];
            end
            `BRSA_OP_ROT_LC_W: begin
                res     = {mem_data_i[6:0], flags_q[`BRSA_FLAG_C]};
                wr_work = 1'b1;
                upd_c   = 1'b1;
                new_c   = mem_data_i[7];
            end
            `BRSA_OP_ROT_R_M: begin
                res    = {mem_data_i[0], mem_data_i[7:1]};
                wr_mem = 1'b1;
            end
            `BRSA_OP_ROT_R_W: begin
                res     = {mem_data_i[0], mem_data_i[7:1]};
                wr_work = 1'b1;
            end
            `BRSA_OP_ROT_RC_M: begin
                res    = {flags_q[`BRSA_FLAG_C], mem_data_i[7:1]};
                wr_mem = 1'b1;
                upd_c  = 1'b1;
                new_c  = mem_data_i[0];
            end
            `BRSA_OP_ROT_RC_W: begin
                res     = {flags_q[`BRSA_FLAG_C], mem_data_i[7:1]};
                wr_work = 1'b1;
                upd_c   = 1'b1;
                new_c   = mem_data_i[0];
            end
            `BRSA_OP_MWB_W, `BRSA_OP_MWB_IMM, `BRSA_OP_SUB_W, `BRSA_OP_SUB_IMM: begin
                res       = sub_diff;
                wr_work   = 1'b1;
                upd_arith = 1'b1;
            end
            `BRSA_OP_MWB_M, `BRSA_OP_SUB_M: begin
                res       = sub_diff;
                wr_mem    = 1'b1;
                upd_arith = 1'b1;
            end
            `BRSA_OP_DSZ_M: begin
                res     = dec_v;
                wr_mem  = 1'b1;
                do_skip = (dec_v == 8'h00);
            end
            `BRSA_OP_DSZ_W: begin
                res     = dec_v;
                wr_work = 1'b1;
                do_skip = (dec_v == 8'h00);
            end
            `BRSA_OP_ISZ_M: begin
                res     = inc_v;
                wr_mem  = 1'b1;
                do_skip = (inc_v == 8'h00);
            end
            `BRSA_OP_ISZ_W: begin
                res     = inc_v;
                wr_work = 1'b1;
                do_skip = (inc_v == 8'h00);
            end
            `BRSA_OP_NZ_BYTE: begin
                do_skip = (mem_data_i != 8'h00);
            end
            `BRSA_OP_NZ_BIT: begin
                do_skip = |(mem_data_i & bit_mask);
            end
            `BRSA_OP_SET_BYTE: begin
                res    = `BRSA_ALL_ONES;
                wr_mem = 1'b1;
            end
            `BRSA_OP_SET_BIT: begin
                res    = mem_data_i | bit_mask;
                wr_mem = 1'b1;
            end
            `BRSA_OP_SWAP_M: begin
                res    = {mem_data_i[3:0], mem_data_i[7:4]};
                wr_mem = 1'b1;
            end
            default: begin
                res = mem_data_i;
            end
        endcase
    end

    // ======================================================================
    // Working register
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            work_q <= `BRSA_RST_BYTE;
        end else if (issue_i && !skip_q && wr_work) begin
            work_q <= res;
        end
    end

    // ======================================================================
    // Flags; non-arithmetic ops leave everything but carry alone
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flags_q <= `BRSA_RST_FLAGS;
        end else if (issue_i && !skip_q) begin
            if (upd_arith) begin
                flags_q <= sub_flags;
            end else if (upd_c) begin
                flags_q[`BRSA_FLAG_C] <= new_c;
            end
        end
    end

    // ======================================================================
    // Memory write back, one cycle after issue
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mem_we_q    <= 1'b0;
            mem_wdata_q <= `BRSA_RST_BYTE;
        end else begin
            mem_we_q <= issue_i && !skip_q && wr_mem;
            if (issue_i && !skip_q && wr_mem) begin
                mem_wdata_q <= res;
            end
        end
    end

    // ======================================================================
    // Skip: the next issue slot becomes a dummy cycle and is discarded
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            skip_q <= 1'b0;
        end else if (skip_q) begin
            skip_q <= issue_i ? 1'b0 : skip_q;
        end else begin
            skip_q <= issue_i && do_skip;
        end
    end

    assign working_register_o            = work_q;
    assign carry_flag_o                  = flags_q[`BRSA_FLAG_C];
    assign half_carry_flag_o             = flags_q[`BRSA_FLAG_HALF];
    assign zero_flag_o                   = flags_q[`BRSA_FLAG_Z];
    assign twos_complement_excess_flag_o = flags_q[`BRSA_FLAG_EXCESS];
    assign signed_borrow_bit_o           = flags_q[`BRSA_FLAG_SIGN];
    assign multi_byte_zero_bit_o         = flags_q[`BRSA_FLAG_MBZ];
    assign mem_we_o                      = mem_we_q;
    assign mem_wdata_o                   = mem_wdata_q;
    assign skip_o                        = skip_q;
    assign busy_o                        = skip_q;

endmodule : brsa_alu

// ===== tb/brsa_alu_sva.sv
// Assertion checker for the rotate/subtract/skip datapath
`timescale 1ns/1ps
`include "brsa_defines.svh"

module brsa_alu_sva (
    // Clock and reset
    input wire logic               sys_clk_i,
    input wire logic               nrst_i,
    // Issue
    input wire logic               issue_i,
    input wire brsa_pkg::brsa_op_t op_i,
    input wire logic [7:0]         mem_data_i,
    input wire logic [2:0]         bit_sel_i,
    // Results
    input wire logic [7:0]         working_register_o,
    input wire logic               carry_flag_o,
    input wire logic               mem_we_o,
    input wire logic [7:0]         mem_wdata_o,
    input wire logic               skip_o
);
    // ======================================================================
    // Helpers
    logic       go;
    logic       sel_bit;
    logic [7:0] m_q;
    logic [7:0] w_q;
    logic       c_q;
    logic       sel_q;
    assign go = issue_i & ~skip_o;
    assign sel_bit = mem_data_i[bit_sel_i];
    // Operand copies avoid slicing a past value
    always_ff @(posedge sys_clk_i) begin
        {m_q, w_q, c_q, sel_q} <= {mem_data_i, working_register_o, carry_flag_o, sel_bit};
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    // ======================================================================
    // Properties
    chk_we_cause: assert property (mem_we_o |-> $past(go))
        else $error("write without accepted issue");
    chk_refused_quiet: assert property (skip_o && issue_i |=> !mem_we_o && !skip_o)
        else $error("dropped issue had an effect");
    chk_rot_left_w: assert property (go && op_i == `BRSA_OP_ROT_L_W |=>
        !mem_we_o && working_register_o == {m_q[6:0], m_q[7]} && carry_flag_o == c_q)
        else $error("left rotate to working wrong");
    chk_rot_lc_mem: assert property (go && op_i == `BRSA_OP_ROT_LC_M |=>
        mem_we_o && mem_wdata_o == {m_q[6:0], c_q} && carry_flag_o == m_q[7])
        else $error("left rotate through carry wrong");
    chk_rot_rc_w: assert property (go && op_i == `BRSA_OP_ROT_RC_W |=>
        !mem_we_o && working_register_o == {c_q, m_q[7:1]} && carry_flag_o == m_q[0])
        else $error("right rotate through carry wrong");
    chk_sub_carry: assert property (go && op_i == `BRSA_OP_SUB_W |=>
        carry_flag_o == (w_q >= m_q))
        else $error("subtract carry wrong");
    chk_dec_skip: assert property (go && op_i == `BRSA_OP_DSZ_M |=>
        mem_we_o && mem_wdata_o == m_q - 8'h01 && skip_o == (m_q == 8'h01))
        else $error("decrement skip wrong");
    chk_inc_skip_w: assert property (go && op_i == `BRSA_OP_ISZ_W |=>
        !mem_we_o && working_register_o == m_q + 8'h01 && skip_o == (m_q == 8'hFF))
        else $error("increment skip wrong");
    chk_bit_skip: assert property (go && op_i == `BRSA_OP_NZ_BIT |=> skip_o == sel_q)
        else $error("bit test skip wrong");
    chk_swap_mem: assert property (go && op_i == `BRSA_OP_SWAP_M |=>
        mem_we_o && mem_wdata_o == {m_q[3:0], m_q[7:4]})
        else $error("nibble swap wrong");
    cover property (go && op_i == `BRSA_OP_DSZ_M ##1 skip_o);
    cover property (skip_o && issue_i);
    cover property (go && op_i == `BRSA_OP_MWB_M ##1 mem_we_o);
endmodule : brsa_alu_sva

bind brsa_alu brsa_alu_sva chk_u (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .issue_i(issue_i), .op_i(op_i),
    .mem_data_i(mem_data_i), .bit_sel_i(bit_sel_i), .working_register_o(working_register_o),
    .carry_flag_o(carry_flag_o), .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o),
    .skip_o(skip_o)
);

// ===== tb/testbench.sv
// Self-checking bench for the rotate/subtract/skip datapath
`timescale 1ns/1ps
`include "brsa_defines.svh"

module testbench;
    // ======================================================================
    // Signals and model state
    logic                  sys_clk_i = 1'b0;
    logic                  nrst_i = 1'b0;
    logic                  issue_i = 1'b0;
    brsa_pkg::brsa_op_t    op_i = `BRSA_OP_NOP;
    logic [7:0]            mem_data_i = 8'h00;
    logic [7:0]            imm_i = 8'h00;
    logic [2:0]            bit_sel_i = 3'h0;
    logic                  mbz_chain_i = 1'b0;
    logic [7:0]            wr_o;
    logic [7:0]            wd_o;
    logic                  c_o, hc_o, z_o, xs_o, sb_o, mz_o, we_o, skip_o, busy_o;
    logic [7:0]            m_w = 8'h00;
    logic [7:0]            m_wd = 8'h00;
    brsa_pkg::brsa_flags_t m_f = 6'h00;
    int                    failures = 0;
    int                    total_checks = 0;
    int                    cyc = 0;

    brsa_alu dut_u (
        .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .issue_i(issue_i), .op_i(op_i),
        .mem_data_i(mem_data_i), .imm_i(imm_i), .bit_sel_i(bit_sel_i),
        .mbz_chain_i(mbz_chain_i), .working_register_o(wr_o), .carry_flag_o(c_o),
        .half_carry_flag_o(hc_o), .zero_flag_o(z_o), .twos_complement_excess_flag_o(xs_o),
        .signed_borrow_bit_o(sb_o), .multi_byte_zero_bit_o(mz_o), .mem_we_o(we_o),
        .mem_wdata_o(wd_o), .skip_o(skip_o), .busy_o(busy_o)
    );

    always #12.5 sys_clk_i = ~sys_clk_i;
    // A hang would otherwise never reach the verdict
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            wrap_up();
        end
    end

    // ======================================================================
    // Shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Flags packed {mbz, sign, excess, z, half, c} above the byte result
    function automatic logic [13:0] sub(input logic [7:0] a, s, input logic b, ch);
        logic [8:0] d;
        logic [4:0] h;
        logic [8:0] g;
        d = {1'b0, a} - {1'b0, s} - b;
        h = {1'b0, a[3:0]} - {1'b0, s[3:0]} - b;
        g = {a[7], a} - {s[7], s} - b;
        return {(d[7:0] == 8'h00) & (~ch | m_f[`BRSA_FLAG_Z]), g[8],
                (a[7] ^ s[7]) & (d[7] ^ a[7]), d[7:0] == 8'h00, ~h[4], ~d[8], d[7:0]};
    endfunction : sub

    // Entered and left just after a falling edge, so issues run back to back
    task automatic step(input brsa_pkg::brsa_op_t op, input logic [7:0] m, x,
                        input logic [2:0] bs);
        logic [7:0]            nw;
        brsa_pkg::brsa_flags_t nf;
        logic                  we;
        logic [7:0]            wd;
        logic                  sk;
        logic                  c;
        nw = m_w;
        nf = m_f;
        we = 1'b0;
        wd = 8'h00;
        sk = 1'b0;
        c = m_f[`BRSA_FLAG_C];
        case (op)
            `BRSA_OP_ROT_L_W:  nw = {m[6:0], m[7]};
            `BRSA_OP_ROT_LC_M: {we, wd, nf[0]} = {1'b1, m[6:0], c, m[7]};
            `BRSA_OP_ROT_LC_W: {nw, nf[0]} = {m[6:0], c, m[7]};
            `BRSA_OP_ROT_R_M:  {we, wd} = {1'b1, m[0], m[7:1]};
            `BRSA_OP_ROT_R_W:  nw = {m[0], m[7:1]};
            `BRSA_OP_ROT_RC_M: {we, wd, nf[0]} = {1'b1, c, m[7:1], m[0]};
            `BRSA_OP_ROT_RC_W: {nw, nf[0]} = {c, m[7:1], m[0]};
            `BRSA_OP_MWB_W:    {nf, nw} = sub(m_w, m, ~c, bs[0]);
            `BRSA_OP_MWB_IMM:  {nf, nw} = sub(m_w, x, ~c, bs[0]);
            `BRSA_OP_MWB_M:    {we, nf, wd} = {1'b1, sub(m_w, m, ~c, bs[0])};
            `BRSA_OP_SUB_W:    {nf, nw} = sub(m_w, m, 1'b0, bs[0]);
            `BRSA_OP_SUB_M:    {we, nf, wd} = {1'b1, sub(m_w, m, 1'b0, bs[0])};
            `BRSA_OP_SUB_IMM:  {nf, nw} = sub(m_w, x, 1'b0, bs[0]);
            `BRSA_OP_DSZ_M:    {we, wd, sk} = {1'b1, m - 8'h01, m == 8'h01};
            `BRSA_OP_DSZ_W:    {nw, sk} = {m - 8'h01, m == 8'h01};
            `BRSA_OP_ISZ_M:    {we, wd, sk} = {1'b1, m + 8'h01, m == 8'hFF};
            `BRSA_OP_ISZ_W:    {nw, sk} = {m + 8'h01, m == 8'hFF};
            `BRSA_OP_NZ_BYTE:  sk = m != 8'h00;
            `BRSA_OP_NZ_BIT:   sk = m[bs];
            `BRSA_OP_SET_BYTE: {we, wd} = {1'b1, `BRSA_ALL_ONES};
            `BRSA_OP_SET_BIT:  {we, wd} = {1'b1, m | (8'h01 << bs)};
            `BRSA_OP_SWAP_M:   {we, wd} = {1'b1, m[3:0], m[7:4]};
            default: ;
        endcase
        op_i = op;
        mem_data_i = m;
        imm_i = x;
        bit_sel_i = bs;
        mbz_chain_i = bs[0];
        issue_i = 1'b1;
        @(negedge sys_clk_i);
        check({wr_o, mz_o, sb_o, xs_o, z_o, hc_o, c_o, we_o, skip_o}, {nw, nf, we, sk});
        check({busy_o, wd_o}, {sk, we ? wd : m_wd});
        m_w = nw;
        m_f = nf;
        m_wd = we ? wd : m_wd;
        // A write op is offered as the dummy so a leak would show
        if (sk) begin
            op_i = `BRSA_OP_SET_BYTE;
            @(negedge sys_clk_i);
            check({wr_o, c_o, we_o, skip_o}, {m_w, m_f[`BRSA_FLAG_C], 2'b00});
        end
    endtask : step

    task automatic idle();
        issue_i = 1'b0;
        @(negedge sys_clk_i);
        check({15'h0000, we_o}, 16'h0000);
    endtask : idle

    task automatic load(input logic [7:0] v);
        step(`BRSA_OP_ROT_L_W, {v[0], v[7:1]}, 8'h00, 3'h0);
    endtask : load

    // ======================================================================
    // Scenarios
    task automatic t_rotate();
        for (int k = 0; k < 14; k++) begin
            step(brsa_pkg::brsa_op_t'(`BRSA_OP_ROT_L_W + k % 7), k < 7 ? 8'h81 : 8'h7E,
                 8'h00, 3'h0);
        end
        idle();
    endtask : t_rotate

    task automatic t_subtract();
        logic [15:0] tbl [5];
        tbl = '{16'h0507, 16'h8001, 16'h0000, 16'h1001, 16'h7FFF};
        for (int k = 0; k < 30; k++) begin
            load(tbl[k % 5][15:8]);
            step(brsa_pkg::brsa_op_t'(`BRSA_OP_MWB_W + k / 5), tbl[k % 5][7:0],
                 tbl[k % 5][7:0], k[2:0]);
        end
        idle();
    endtask : t_subtract

    task automatic t_skip();
        for (int k = 0; k < 18; k++) begin
            step(brsa_pkg::brsa_op_t'(`BRSA_OP_DSZ_M + k / 3),
                 k % 3 == 0 ? 8'h00 : (k % 3 == 1 ? 8'h01 : 8'hFF), 8'h00, k[2:0]);
        end
        idle();
    endtask : t_skip

    task automatic t_set();
        step(`BRSA_OP_SET_BYTE, 8'h5A, 8'h00, 3'h0);
        for (int k = 0; k < 8; k++) begin
            step(`BRSA_OP_SET_BIT, k[0] ? 8'h00 : 8'hA5, 8'h00, k[2:0]);
        end
        step(`BRSA_OP_SWAP_M, 8'h3C, 8'h00, 3'h0);
        step(`BRSA_OP_SWAP_M, 8'hF1, 8'h00, 3'h0);
        step(5'h1F, 8'h00, 8'h00, 3'h0);
        idle();
    endtask : t_set

    task automatic t_reset();
        load(8'hC3);
        nrst_i = 1'b0;
        issue_i = 1'b0;
        @(negedge sys_clk_i);
        check({wr_o, mz_o, sb_o, xs_o, z_o, hc_o, c_o, we_o, skip_o}, 16'h0000);
        check({8'h00, wd_o}, 16'h0000);
        nrst_i = 1'b1;
        m_w = 8'h00;
        m_f = 6'h00;
        m_wd = 8'h00;
        step(`BRSA_OP_SUB_IMM, 8'h00, 8'h01, 3'h0);
        idle();
    endtask : t_reset

    task automatic wrap_up();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (5) @(negedge sys_clk_i);
        nrst_i = 1'b1;
        t_rotate();
        t_subtract();
        t_skip();
        t_set();
        t_reset();
        wrap_up();
    end
endmodule : testbench
